/* File: core/tmr_pkg.sv */
// Package of register map, field layout, modes and counts for the 16-bit timer
package tmr_pkg;

	// Register byte addresses, one aligned word each, data in bits 7:0
	localparam logic [7:0] ADDR_CTRL_A = 8'h00;
	localparam logic [7:0] ADDR_CTRL_B = 8'h04;
	localparam logic [7:0] ADDR_CNT_LO = 8'h08;
	localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
	localparam logic [7:0] ADDR_CMPA_LO = 8'h10;
	localparam logic [7:0] ADDR_CMPA_HI = 8'h14;
	localparam logic [7:0] ADDR_CMPB_LO = 8'h18;
	localparam logic [7:0] ADDR_CMPB_HI = 8'h1C;
	localparam logic [7:0] ADDR_CAP_LO = 8'h20;
	localparam logic [7:0] ADDR_CAP_HI = 8'h24;
	localparam logic [7:0] ADDR_FLAG = 8'h28;
	localparam logic [7:0] ADDR_MASK = 8'h2C;

	// Control B fields
	localparam int CS_LSB = 0;
	localparam int MODE_HI_LSB = 3;
	localparam int CAP_SRC_BIT = 5;
	localparam int CAP_EDGE_BIT = 6;
	localparam int CAP_FILT_BIT = 7;
	// Control A field
	localparam int MODE_LO_LSB = 0;

	// Flag and mask bit positions
	localparam int FLG_OVF = 0;
	localparam int FLG_MATCH_A = 1;
	localparam int FLG_MATCH_B = 2;
	localparam int FLG_CAPTURE = 3;
	localparam int FLG_W = 4;

	// Clock select codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	// Prescaler masks, tick when all masked bits are set
	localparam int PRESC_W = 10;
	localparam logic [9:0] MASK_DIV8 = 10'h007;
	localparam logic [9:0] MASK_DIV64 = 10'h03F;
	localparam logic [9:0] MASK_DIV256 = 10'h0FF;
	localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

	// Count sequence modes
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_PWM8 = 4'h1;
	localparam logic [3:0] MODE_PWM9 = 4'h2;
	localparam logic [3:0] MODE_PWM10 = 4'h3;
	localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
	localparam logic [3:0] MODE_CTC_CAP = 4'hC;
	localparam logic [3:0] MODE_PWM_CAP = 4'hE;
	localparam logic [3:0] MODE_PWM_CMPA = 4'hF;

	// Count limits
	localparam logic [15:0] CNT_BOTTOM = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;

	// Capture noise filter length in samples
	localparam int FILT_LEN = 4;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tmr_pkg

/* File: core/tmr_cap_if.sv */
// Interface between timer core and its capture input conditioner
`timescale 1ns/10ps
interface tmr_cap_if;
	logic capPin;
	logic cmpOut;
	logic useCmp;
	logic riseEdge;
	logic filterOn;
	logic capEvent;

	modport core (
		output capPin,
		output cmpOut,
		output useCmp,
		output riseEdge,
		output filterOn,
		input capEvent
	);

	modport unit (
		input capPin,
		input cmpOut,
		input useCmp,
		input riseEdge,
		input filterOn,
		output capEvent
	);
endinterface : tmr_cap_if

/* File: core/tmr_capture_unit.sv */
// Capture input synchroniser, noise filter and edge detector
`timescale 1ns/10ps
module tmr_capture_unit #(
	parameter int FILT_LEN = tmr_pkg::FILT_LEN
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Conditioner link
	tmr_cap_if.unit cap
);

	logic pinMeta_q;
	logic pinSync_q;
	logic cmpMeta_q;
	logic cmpSync_q;
	logic [FILT_LEN-1:0] hist_q;
	logic filtLvl_q;
	logic prevLvl_q;
	logic event_q;
	logic srcLvl;
	logic curLvl;

	// Two-stage synchronisers for both sources
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pinMeta_q <= 1'b0;
			pinSync_q <= 1'b0;
			cmpMeta_q <= 1'b0;
			cmpSync_q <= 1'b0;
		end else begin
			pinMeta_q <= cap.capPin;
			pinSync_q <= pinMeta_q;
			cmpMeta_q <= cap.cmpOut;
			cmpSync_q <= cmpMeta_q;
		end
	end

	assign srcLvl = cap.useCmp ? cmpSync_q : pinSync_q;

	// Filter level changes only when all samples agree
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hist_q <= '0;
			filtLvl_q <= 1'b0;
		end else begin
			hist_q <= {hist_q[FILT_LEN-2:0], srcLvl};
			if (&hist_q) begin
				filtLvl_q <= 1'b1;
			end else if (~|hist_q) begin
				filtLvl_q <= 1'b0;
			end
		end
	end

	assign curLvl = cap.filterOn ? filtLvl_q : srcLvl;

	// Edge detector on the selected edge
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			prevLvl_q <= 1'b0;
			event_q <= 1'b0;
		end else begin
			prevLvl_q <= curLvl;
			event_q <= cap.riseEdge ? (curLvl && !prevLvl_q) : (!curLvl && prevLvl_q);
		end
	end

	assign cap.capEvent = event_q;

endmodule : tmr_capture_unit

/* File: core/tmr_timer16_core.sv */
// Sixteen-bit timer with byte-wide register access over AXI4-Lite
//
// Function
// - Counter, compares, capture are byte-accessed 16-bit
// - One shared high-byte holding register
// - Low-byte write loads holding plus low
// - Counter or capture low-byte read copies high into holding
// - Compare reads return high byte directly
// - Bottom is 0x0000, maximum is 0xFFFF
// - Top from fixed values, compare A, capture
// - Compare A as top disables A PWM
// - Compare match sets flag, drives waveform
// - Capture on chosen edge, optional filter
// - Prescaler or external edge clocks counter
// - Four flags each with mask enable
// - Control registers are plain 8-bit
// - Counter high location reaches holding register only
// - Counter write beats clear and count
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
module tmr_timer16_core (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Timer pins and power control
	input wire logic capturePin,
	input wire logic comparatorOut,
	input wire logic externalCountPin,
	input wire logic timerPowerOff,
	// Outputs
	output logic waveformOutA,
	output logic waveformOutB,
	output logic irq
);

	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [7:0] ctrlA_q, ctrlB_q, hold_q;
	logic [15:0] count_q, cmpABuf_q, cmpBBuf_q, cmpA_q, cmpB_q, capture_q;
	logic [tmr_pkg::FLG_W-1:0] flags_q, flags_d, mask_q, events, clrBits;
	logic [tmr_pkg::PRESC_W-1:0] presc_q;
	logic extMeta_q, extSync_q, extPrev_q, block_q, irq_q, waveA_q, waveB_q;
	logic wrFire, rdFire, wrEn;
	logic [7:0] wrByte, rdByte;
	logic wrCtrlA, wrCtrlB, wrHigh, wrCntLo, wrCmpALo, wrCmpBLo, wrCapLo, wrFlag, wrMask, wrOk;
	logic rdCntLo, rdCapLo, rdOk;
	logic [2:0] clkSel;
	logic [3:0] mode;
	logic tick, isPwm, capIsTop, atTop, atWrap;
	logic [15:0] topVal;

	tmr_cap_if capLink();

	tmr_capture_unit #(
		.FILT_LEN(tmr_pkg::FILT_LEN)
	) u_capture (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.cap(capLink.unit)
	);

	assign capLink.capPin = capturePin;
	assign capLink.cmpOut = comparatorOut;
	assign capLink.useCmp = ctrlB_q[tmr_pkg::CAP_SRC_BIT];
	assign capLink.riseEdge = ctrlB_q[tmr_pkg::CAP_EDGE_BIT];
	assign capLink.filterOn = ctrlB_q[tmr_pkg::CAP_FILT_BIT];

	// Bus handshakes: write readies pulse once both address and data are offered, read ready once the address is
	assign wrFire = awready_q && wready_q && s_axi_awvalid && s_axi_wvalid;
	assign rdFire = arready_q && s_axi_arvalid;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= tmr_pkg::RESP_OKAY;
		end else begin
			awready_q <= s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
			wready_q <= s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
			if (wrFire) begin
				bvalid_q <= 1'b1;
				bresp_q <= wrOk ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= tmr_pkg::RESP_OKAY;
		end else begin
			arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
			if (rdFire) begin
				rvalid_q <= 1'b1;
				rdata_q <= {24'h000000, rdByte};
				rresp_q <= rdOk ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Write decode, data in byte lane 0
	assign wrEn = wrFire && s_axi_wstrb[0];
	assign wrByte = s_axi_wdata[7:0];

	always_comb begin
		wrCtrlA = 1'b0;
		wrCtrlB = 1'b0;
		wrHigh = 1'b0;
		wrCntLo = 1'b0;
		wrCmpALo = 1'b0;
		wrCmpBLo = 1'b0;
		wrCapLo = 1'b0;
		wrFlag = 1'b0;
		wrMask = 1'b0;
		wrOk = 1'b1;
		if (s_axi_awaddr == tmr_pkg::ADDR_CTRL_A) begin
			wrCtrlA = wrEn;
		end else if (s_axi_awaddr == tmr_pkg::ADDR_CTRL_B) begin
			wrCtrlB = wrEn;
		end else if (s_axi_awaddr == tmr_pkg::ADDR_CNT_LO) begin
			wrCntLo = wrEn;
		end else if (s_axi_awaddr == tmr_pkg::ADDR_CMPA_LO) begin
			wrCmpALo = wrEn;
		end else if (s_axi_awaddr == tmr_pkg::ADDR_CMPB_LO) begin
			wrCmpBLo = wrEn;
		end else if (s_axi_awaddr == tmr_pkg::ADDR_CAP_LO) begin
			wrCapLo = wrEn;
		end else if (s_axi_awaddr == tmr_pkg::ADDR_CNT_HI || s_axi_awaddr == tmr_pkg::ADDR_CMPA_HI
			|| s_axi_awaddr == tmr_pkg::ADDR_CMPB_HI || s_axi_awaddr == tmr_pkg::ADDR_CAP_HI) begin
			wrHigh = wrEn;
		end else if (s_axi_awaddr == tmr_pkg::ADDR_FLAG) begin
			wrFlag = wrEn;
		end else if (s_axi_awaddr == tmr_pkg::ADDR_MASK) begin
			wrMask = wrEn;
		end else begin
			wrOk = 1'b0;
		end
	end

	// Read decode
	always_comb begin
		rdByte = 8'h00;
		rdCntLo = 1'b0;
		rdCapLo = 1'b0;
		rdOk = 1'b1;
		if (s_axi_araddr == tmr_pkg::ADDR_CTRL_A) begin
			rdByte = ctrlA_q;
		end else if (s_axi_araddr == tmr_pkg::ADDR_CTRL_B) begin
			rdByte = ctrlB_q;
		end else if (s_axi_araddr == tmr_pkg::ADDR_CNT_LO) begin
			rdByte = count_q[7:0];
			rdCntLo = rdFire;
		end else if (s_axi_araddr == tmr_pkg::ADDR_CAP_LO) begin
			rdByte = capture_q[7:0];
			rdCapLo = rdFire;
		end else if (s_axi_araddr == tmr_pkg::ADDR_CNT_HI || s_axi_araddr == tmr_pkg::ADDR_CAP_HI) begin
			rdByte = hold_q;
		end else if (s_axi_araddr == tmr_pkg::ADDR_CMPA_LO) begin
			rdByte = cmpABuf_q[7:0];
		end else if (s_axi_araddr == tmr_pkg::ADDR_CMPA_HI) begin
			rdByte = cmpABuf_q[15:8];
		end else if (s_axi_araddr == tmr_pkg::ADDR_CMPB_LO) begin
			rdByte = cmpBBuf_q[7:0];
		end else if (s_axi_araddr == tmr_pkg::ADDR_CMPB_HI) begin
			rdByte = cmpBBuf_q[15:8];
		end else if (s_axi_araddr == tmr_pkg::ADDR_FLAG) begin
			rdByte = {{(8-tmr_pkg::FLG_W){1'b0}}, flags_q};
		end else if (s_axi_araddr == tmr_pkg::ADDR_MASK) begin
			rdByte = {{(8-tmr_pkg::FLG_W){1'b0}}, mask_q};
		end else begin
			rdOk = 1'b0;
		end
	end

	// Shared holding register, a write wins over a read copy
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hold_q <= 8'h00;
		end else if (wrHigh) begin
			hold_q <= wrByte;
		end else if (rdCntLo) begin
			hold_q <= count_q[15:8];
		end else if (rdCapLo) begin
			hold_q <= capture_q[15:8];
		end
	end

	// Control registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrlA_q <= 8'h00;
			ctrlB_q <= 8'h00;
		end else begin
			if (wrCtrlA) begin
				ctrlA_q <= wrByte;
			end
			if (wrCtrlB) begin
				ctrlB_q <= wrByte;
			end
		end
	end

	assign clkSel = ctrlB_q[tmr_pkg::CS_LSB +: 3];
	assign mode = {ctrlB_q[tmr_pkg::MODE_HI_LSB +: 2], ctrlA_q[tmr_pkg::MODE_LO_LSB +: 2]};
	assign isPwm = (mode == tmr_pkg::MODE_PWM8) || (mode == tmr_pkg::MODE_PWM9)
		|| (mode == tmr_pkg::MODE_PWM10) || (mode == tmr_pkg::MODE_PWM_CAP)
		|| (mode == tmr_pkg::MODE_PWM_CMPA);
	assign capIsTop = (mode == tmr_pkg::MODE_CTC_CAP) || (mode == tmr_pkg::MODE_PWM_CAP);

	// Top of the count sequence by mode
	always_comb begin
		case (mode)
			tmr_pkg::MODE_PWM8: topVal = tmr_pkg::TOP_8BIT;
			tmr_pkg::MODE_PWM9: topVal = tmr_pkg::TOP_9BIT;
			tmr_pkg::MODE_PWM10: topVal = tmr_pkg::TOP_10BIT;
			tmr_pkg::MODE_CTC_CMPA, tmr_pkg::MODE_PWM_CMPA: topVal = cmpA_q;
			tmr_pkg::MODE_CTC_CAP, tmr_pkg::MODE_PWM_CAP: topVal = capture_q;
			default: topVal = tmr_pkg::CNT_MAX;
		endcase
	end

	assign atTop = (count_q == topVal);
	assign atWrap = isPwm ? atTop : (count_q == tmr_pkg::CNT_MAX);

	// External count pin synchroniser and prescaler
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			extMeta_q <= 1'b0;
			extSync_q <= 1'b0;
			extPrev_q <= 1'b0;
		end else begin
			extMeta_q <= externalCountPin;
			extSync_q <= extMeta_q;
			extPrev_q <= extSync_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || clkSel == tmr_pkg::CS_STOP || timerPowerOff) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_q + 1'b1;
		end
	end

	// Timer tick selection, no tick when stopped or powered off
	always_comb begin
		case (clkSel)
			tmr_pkg::CS_DIV1: tick = 1'b1;
			tmr_pkg::CS_DIV8: tick = (presc_q & tmr_pkg::MASK_DIV8) == tmr_pkg::MASK_DIV8;
			tmr_pkg::CS_DIV64: tick = (presc_q & tmr_pkg::MASK_DIV64) == tmr_pkg::MASK_DIV64;
			tmr_pkg::CS_DIV256: tick = (presc_q & tmr_pkg::MASK_DIV256) == tmr_pkg::MASK_DIV256;
			tmr_pkg::CS_DIV1024: tick = presc_q == tmr_pkg::MASK_DIV1024;
			tmr_pkg::CS_EXT_FALL: tick = !extSync_q && extPrev_q;
			tmr_pkg::CS_EXT_RISE: tick = extSync_q && !extPrev_q;
			default: tick = 1'b0;
		endcase
		if (timerPowerOff) begin
			tick = 1'b0;
		end
	end

	// Counter
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			count_q <= tmr_pkg::CNT_BOTTOM;
		end else if (wrCntLo) begin
			count_q <= {hold_q, wrByte};
		end else if (tick) begin
			count_q <= atTop ? tmr_pkg::CNT_BOTTOM : count_q + 16'h0001;
		end
	end

	// A counter write suppresses matches up to and including the next tick
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			block_q <= 1'b0;
		end else if (wrCntLo) begin
			block_q <= 1'b1;
		end else if (tick) begin
			block_q <= 1'b0;
		end
	end

	// Compare buffers and active compare values
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cmpABuf_q <= 16'h0000;
			cmpBBuf_q <= 16'h0000;
		end else begin
			if (wrCmpALo) begin
				cmpABuf_q <= {hold_q, wrByte};
			end
			if (wrCmpBLo) begin
				cmpBBuf_q <= {hold_q, wrByte};
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cmpA_q <= 16'h0000;
			cmpB_q <= 16'h0000;
		end else if (!isPwm || (tick && atTop)) begin
			cmpA_q <= cmpABuf_q;
			cmpB_q <= cmpBBuf_q;
		end
	end

	// Capture register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			capture_q <= 16'h0000;
		end else if (wrCapLo) begin
			capture_q <= {hold_q, wrByte};
		end else if (capLink.capEvent && !capIsTop) begin
			capture_q <= count_q;
		end
	end

	// Events and sticky flags, a set beats a same-cycle clear
	always_comb begin
		events = '0;
		events[tmr_pkg::FLG_OVF] = tick && !wrCntLo && atWrap;
		events[tmr_pkg::FLG_MATCH_A] = tick && !wrCntLo && !block_q && (count_q == cmpA_q);
		events[tmr_pkg::FLG_MATCH_B] = tick && !wrCntLo && !block_q && (count_q == cmpB_q);
		events[tmr_pkg::FLG_CAPTURE] = capLink.capEvent && !capIsTop;
		clrBits = wrFlag ? wrByte[tmr_pkg::FLG_W-1:0] : '0;
		flags_d = (flags_q & ~clrBits) | events;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flags_q <= '0;
			mask_q <= '0;
			irq_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			if (wrMask) begin
				mask_q <= wrByte[tmr_pkg::FLG_W-1:0];
			end
			irq_q <= |(flags_d & (wrMask ? wrByte[tmr_pkg::FLG_W-1:0] : mask_q));
		end
	end

	// Waveform outputs: compare in PWM modes, toggle on match otherwise
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			waveA_q <= 1'b0;
			waveB_q <= 1'b0;
		end else if (isPwm) begin
			waveA_q <= (mode != tmr_pkg::MODE_PWM_CMPA) && (count_q < cmpA_q);
			waveB_q <= count_q < cmpB_q;
		end else begin
			if (events[tmr_pkg::FLG_MATCH_A]) begin
				waveA_q <= !waveA_q;
			end
			if (events[tmr_pkg::FLG_MATCH_B]) begin
				waveB_q <= !waveB_q;
			end
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign waveformOutA = waveA_q;
	assign waveformOutB = waveB_q;
	assign irq = irq_q;

endmodule : tmr_timer16_core

/* File: dv/tmr_timer16_core_asserts.sv */
// Bus timing checker for the 16-bit timer core
`timescale 1ns/10ps
module tmr_timer16_core_asserts (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Write side
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read side
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence wrOffer;
		s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	endsequence
	sequence wrTaken;
		s_axi_awready && s_axi_wready;
	endsequence
	sequence rdTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	wr_pair_a: assert property (s_axi_awready |-> s_axi_wready && s_axi_wvalid)
		else $error("write address taken without write data");
	wr_take_a: assert property (wrOffer |=> wrTaken)
		else $error("write not taken one cycle after offer");
	wr_answer_a: assert property (wrTaken |=> s_axi_bvalid && !s_axi_awready)
		else $error("write response missing after handshake");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	rd_take_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> rdTaken)
		else $error("read not taken one cycle after offer");
	rd_answer_a: assert property (rdTaken |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data missing after handshake");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before rready");
	rd_byte_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data wider than one byte");
	rd_unmapped_a: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
		else $error("error read returned data");
endmodule : tmr_timer16_core_asserts
bind tmr_timer16_core tmr_timer16_core_asserts chk_i (.*);

/* File: dv/tmr_cpu_model.sv */
// Processor-side bus master model doing byte accesses
`timescale 1ns/10ps
module tmr_cpu_model (
	// Clock
	input wire logic core_clk,
	// Write channels
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// Read channels
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		logic ra;
		logic rw;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge core_clk);
			ra = s_axi_awready;
			rw = s_axi_wready;
			@(posedge core_clk);
			if (ra) s_axi_awvalid <= 1'b0;
			if (rw) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid && !ra || s_axi_wvalid && !rw);
		do @(negedge core_clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		@(posedge core_clk);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge core_clk); while (!s_axi_arready);
		@(posedge core_clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge core_clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge core_clk);
		s_axi_rready <= 1'b0;
	endtask : rd
	// High byte first, whole pair without interruption
	task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
		logic [1:0] r;
		wr(lo + 8'h04, v[15:8], r);
		wr(lo, v[7:0], r);
	endtask : wr16
	// Low byte first, whole pair without interruption
	task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
		logic [31:0] d;
		logic [1:0] r;
		rd(lo, d, r);
		v[7:0] = d[7:0];
		rd(lo + 8'h04, d, r);
		v[15:8] = d[7:0];
	endtask : rd16
endmodule : tmr_cpu_model

/* File: dv/tmr_timer16_core_tb.sv */
// Self-checking testbench for the 16-bit timer core
`timescale 1ns/10ps
module tmr_timer16_core_tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic capturePin = 1'b0;
	logic comparatorOut = 1'b0;
	logic externalCountPin = 1'b0;
	logic timerPowerOff = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic waveformOutA, waveformOutB, irq;
	logic [15:0] v, w;
	logic [15:0] last[4];
	logic [31:0] d;
	logic [7:0] lo[4] = '{8'h08, 8'h10, 8'h18, 8'h20};
	int err_total = 0;
	int checked = 0;

	always #5 core_clk = ~core_clk;
	tmr_timer16_core dut (.*);
	tmr_cpu_model cpu (.*);

	function automatic logic [15:0] join16(input logic [7:0] h, input logic [7:0] l);
		return {h, l};
	endfunction : join16
	function automatic logic [15:0] topOf(input int m);
		return (m == 0) ? tmr_pkg::TOP_9BIT : (m == 1) ? tmr_pkg::TOP_10BIT : 16'h0040;
	endfunction : topOf
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("Checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test
	task automatic rdByte(input logic [7:0] a, input logic [15:0] exp);
		cpu.rd(a, d, r);
		chk(16'(d[7:0]), exp);
	endtask : rdByte

	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		end_of_test();
	end

	initial begin
		void'($urandom(83));
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 24; i++) begin
			v = 16'($urandom);
			last[i % 4] = v;
			cpu.wr16(lo[i % 4], v);
			cpu.rd16(lo[i % 4], w);
			chk(w, v);
		end
		cpu.wr(tmr_pkg::ADDR_CMPA_HI, 8'hA5, r);
		cpu.rd16(tmr_pkg::ADDR_CMPA_LO, w);
		chk(w, last[1]);
		cpu.wr(tmr_pkg::ADDR_CMPB_LO, 8'h3C, r);
		cpu.rd16(tmr_pkg::ADDR_CMPB_LO, w);
		chk(w, join16(8'hA5, 8'h3C));
		cpu.rd(tmr_pkg::ADDR_CNT_LO, d, r);
		rdByte(tmr_pkg::ADDR_CMPA_HI, 16'(last[1][15:8]));
		rdByte(tmr_pkg::ADDR_CNT_HI, 16'(last[0][15:8]));
		cpu.wr(tmr_pkg::ADDR_CNT_HI, 8'h5A, r);
		rdByte(tmr_pkg::ADDR_CNT_HI, 16'h005A);
		cpu.rd16(tmr_pkg::ADDR_CNT_LO, w);
		chk(w, last[0]);
		rdByte(8'h30, 16'h0000);
		chk(16'(r), 16'(tmr_pkg::RESP_SLVERR));
		cpu.wr(8'h30, 8'hFF, r);
		chk(16'(r), 16'(tmr_pkg::RESP_SLVERR));
		v = 16'($urandom);
		cpu.wr(tmr_pkg::ADDR_CTRL_B, {v[7:3], 3'h0}, r);
		rdByte(tmr_pkg::ADDR_CTRL_B, {8'h00, v[7:3], 3'h0});
		for (int f = 0; f < 2; f++) begin
			v = 16'($urandom);
			cpu.wr16(tmr_pkg::ADDR_CNT_LO, v);
			cpu.wr(tmr_pkg::ADDR_CTRL_B, (f == 0) ? 8'h40 : 8'h80, r);
			cpu.wr(tmr_pkg::ADDR_FLAG, 8'h0F, r);
			capturePin <= ~capturePin;
			repeat (12) @(posedge core_clk);
			cpu.rd16(tmr_pkg::ADDR_CAP_LO, w);
			chk(w, v);
			rdByte(tmr_pkg::ADDR_FLAG, 16'h0008);
		end
		@(negedge core_clk);
		chk(16'(irq), 16'h0000);
		cpu.wr(tmr_pkg::ADDR_MASK, 8'h08, r);
		@(negedge core_clk);
		chk(16'(irq), 16'h0001);
		cpu.wr(tmr_pkg::ADDR_FLAG, 8'h08, r);
		@(negedge core_clk);
		chk(16'(irq), 16'h0000);
		cpu.wr16(tmr_pkg::ADDR_CNT_LO, 16'hFFF8);
		cpu.wr16(tmr_pkg::ADDR_CMPA_LO, 16'hFFFC);
		cpu.wr16(tmr_pkg::ADDR_CMPB_LO, 16'h0002);
		cpu.wr(tmr_pkg::ADDR_CTRL_B, 8'h01, r);
		repeat (20) @(posedge core_clk);
		cpu.wr(tmr_pkg::ADDR_CTRL_B, 8'h00, r);
		rdByte(tmr_pkg::ADDR_FLAG, 16'h0007);
		@(negedge core_clk);
		chk(16'({waveformOutA, waveformOutB}), 16'h0003);
		cpu.wr(tmr_pkg::ADDR_FLAG, 8'h0F, r);
		cpu.wr(tmr_pkg::ADDR_CTRL_A, 8'h01, r);
		cpu.wr16(tmr_pkg::ADDR_CNT_LO, 16'h00F0);
		cpu.wr(tmr_pkg::ADDR_CTRL_B, 8'h01, r);
		repeat (300) @(posedge core_clk);
		cpu.wr(tmr_pkg::ADDR_CTRL_B, 8'h00, r);
		cpu.rd16(tmr_pkg::ADDR_CNT_LO, w);
		chk(16'(w <= tmr_pkg::TOP_8BIT), 16'h0001);
		cpu.rd(tmr_pkg::ADDR_FLAG, d, r);
		chk(16'(d[0]), 16'h0001);
		for (int m = 0; m < 3; m++) begin
			cpu.wr(tmr_pkg::ADDR_CTRL_A, 8'h00, r);
			cpu.wr16(tmr_pkg::ADDR_CMPA_LO, 16'h0040);
			cpu.wr16(tmr_pkg::ADDR_CNT_LO, topOf(m) - 16'h0010);
			cpu.wr(tmr_pkg::ADDR_FLAG, 8'h0F, r);
			cpu.wr(tmr_pkg::ADDR_CTRL_A, (m == 0) ? 8'h02 : 8'h03, r);
			cpu.wr(tmr_pkg::ADDR_CTRL_B, (m == 2) ? 8'h19 : 8'h01, r);
			repeat (100) @(posedge core_clk);
			@(negedge core_clk);
			if (m == 2) chk(16'(waveformOutA), 16'h0000);
			cpu.wr(tmr_pkg::ADDR_CTRL_B, 8'h00, r);
			cpu.rd16(tmr_pkg::ADDR_CNT_LO, w);
			chk(16'(w <= topOf(m)), 16'h0001);
			cpu.rd(tmr_pkg::ADDR_FLAG, d, r);
			chk(16'(d[0]), 16'h0001);
		end
		cpu.wr(tmr_pkg::ADDR_CTRL_A, 8'h00, r);
		cpu.wr16(tmr_pkg::ADDR_CNT_LO, 16'h0100);
		timerPowerOff <= 1'b1;
		cpu.wr(tmr_pkg::ADDR_CTRL_B, 8'h01, r);
		repeat (50) @(posedge core_clk);
		cpu.wr(tmr_pkg::ADDR_CTRL_B, 8'h07, r);
		timerPowerOff <= 1'b0;
		for (int p = 0; p < 10; p++) begin
			repeat (4) @(posedge core_clk);
			externalCountPin <= ~externalCountPin;
		end
		repeat (8) @(posedge core_clk);
		cpu.wr(tmr_pkg::ADDR_CTRL_B, 8'h00, r);
		cpu.rd16(tmr_pkg::ADDR_CNT_LO, w);
		chk(w, 16'h0105);
		end_of_test();
	end
endmodule : tmr_timer16_core_tb
